/* File: rtl/csw_cfg.svh */
/*
 * Constants of the CPU clock select and oscillator supervisor block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH

// Register byte offsets on the APB bus
`define CSW_OFF_SYSCFG    8'h00
`define CSW_OFF_BUSCFG    8'h04
`define CSW_OFF_IRQ_STAT  8'h08
`define CSW_OFF_IRQ_MASK  8'h0c
`define CSW_OFF_STATE     8'h10
`define CSW_OFF_TIMING    8'h14

// Field positions
`define CSW_SYSCFG_DIS_BIT 4
`define CSW_BUS_MCTC_LSB   0
`define CSW_BUS_MTTC_BIT   5
`define CSW_BUS_ALE_BIT    9

// Reset values
`define CSW_STRAP_RST     3'h7
`define CSW_SYSCFG_RST    32'h0000_0000
`define CSW_BUSCFG_RST    32'h0000_0000
`define CSW_MASK_RST      1'h0
`define CSW_PERIOD_RST    16'hffff

// Strap codes of the non-PLL sources
`define CSW_STRAP_PRESCALE 3'h1
`define CSW_STRAP_DIRECT   3'h3

// Bus timing bases
`define CSW_WAIT_BASE     5'h0f
`define CSW_TRI_BASE      2'h1

// Supervisor overflow after this many free-running PLL ticks
`define CSW_OVF_TICKS     5'h10

// Timing: clock period and free-running PLL period in ns
`define CSW_CLK_NS        5
`define CSW_PLL_FREE_NS   20
`define CSW_PLL_FREE_CYC  (((`CSW_PLL_FREE_NS / `CSW_CLK_NS) < 1) ? 1 : \
	(`CSW_PLL_FREE_NS / `CSW_CLK_NS))

`endif

/* File: rtl/csw_pkg.sv */
/*
 * Types of the CPU clock select and oscillator supervisor block.
 * Assumes nothing of its surroundings.
 */
package csw_pkg;
	// CPU clock source chosen by the straps
	typedef enum logic [1:0] {
		CSW_MODE_PLL      = 2'h0,
		CSW_MODE_DIRECT   = 2'h1,
		CSW_MODE_PRESCALE = 2'h3
	} csw_mode_t;

	// Clock source state: normal, or switched to free PLL after failure
	typedef enum logic [1:0] {
		CSW_SRC_RUN  = 2'h0,
		CSW_SRC_FAIL = 2'h1
	} csw_src_t;
endpackage

/* File: rtl/csw_sync3.sv */
/*
 * Three-stage synchroniser with agreement filter.
 * Assumes d is asynchronous to ref_clk; q is valid four edges after power-up.
 */
`timescale 1ns/1ps
module csw_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] q_nxt;

	// Output moves only once stages two and three agree
	always_comb begin
		q_nxt = (ff2_r == ff3_r) ? ff3_r : q;
	end

	// Stage chain, no reset so levels flow during reset
	always_ff @(posedge ref_clk) begin
		ff1_r <= d;
		ff2_r <= ff1_r;
		ff3_r <= ff2_r;
		q     <= q_nxt;
	end
endmodule // csw_sync3

/* File: rtl/csw_clock_ctrl.sv */
/*
 * CPU clock select, PLL model, oscillator supervisor and bus timing.
 * Assumes an APB master on ref_clk and asynchronous osc and strap pins.
 */
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_clock_ctrl (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        osc_input_pin,
	input  wire logic [2:0]  port0_high_byte,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cpu_clk,
	output logic             cpu_edge,
	output logic             pll_power_on,
	output logic             irq,
	output logic             ale_ext_hp,
	output logic      [4:0]  wait_hp,
	output logic      [1:0]  tristate_hp
);
	logic                osc_s;
	logic [2:0]          strap_s;
	logic [2:0]          strap_r, strap_nxt;
	csw_pkg::csw_mode_t  mode;
	csw_pkg::csw_src_t   src_r, src_nxt;
	logic                osc_prev_r;
	logic                osc_tog, osc_rise;
	logic [31:0]         syscfg_r, syscfg_nxt;
	logic [31:0]         buscfg_r, buscfg_nxt;
	logic                mask_r, mask_nxt;
	logic                flag_r, flag_nxt;
	logic                sup_on;
	logic                pll_run;
	logic [7:0]          free_cnt_r, free_cnt_nxt;
	logic                free_tick;
	logic [3:0]          wd_cnt_r, wd_cnt_nxt;
	logic                wd_ovf;
	logic [2:0]          win_len;
	logic [4:0]          win_edges;
	logic [2:0]          trans_cnt_r, trans_cnt_nxt;
	logic [15:0]         ref_cnt_r, ref_cnt_nxt;
	logic [15:0]         period_r, period_nxt;
	logic [15:0]         acc_r, acc_nxt;
	logic [4:0]          edge_cnt_r, edge_cnt_nxt;
	logic                nco_edge;
	logic                cpu_nxt;
	logic                edge_nxt;
	logic                pll_nxt;
	logic                acc_wr, acc_rd;
	logic [31:0]         rd_nxt;
	logic                rdy_nxt, err_nxt, hit;
	logic                irq_nxt;
	logic                ale_nxt;
	logic [4:0]          wait_nxt;
	logic [1:0]          tri_nxt;

	// Pin synchronisers
	csw_sync3 #(.W(1)) u_sync_osc (
		.ref_clk (ref_clk),
		.d       (osc_input_pin),
		.q       (osc_s)
	);
	csw_sync3 #(.W(3)) u_sync_strap (
		.ref_clk (ref_clk),
		.d       (port0_high_byte),
		.q       (strap_s)
	);

	// Strap latch: follows pins while reset is high, frozen after
	always_comb begin
		strap_nxt = reset ? strap_s : strap_r;
	end

	// Strap code to clock source
	always_comb begin
		unique case (strap_r)
			`CSW_STRAP_PRESCALE: mode = csw_pkg::CSW_MODE_PRESCALE;
			`CSW_STRAP_DIRECT:   mode = csw_pkg::CSW_MODE_DIRECT;
			default:             mode = csw_pkg::CSW_MODE_PLL;
		endcase
	end

	// Resync window in input transitions and CPU edges per window
	always_comb begin
		unique case (strap_r)
			3'h7:    begin win_len = 3'h4; win_edges = 5'h10; end
			3'h6:    begin win_len = 3'h3; win_edges = 5'h09; end
			3'h5:    begin win_len = 3'h2; win_edges = 5'h04; end
			3'h4:    begin win_len = 3'h5; win_edges = 5'h19; end
			3'h2:    begin win_len = 3'h2; win_edges = 5'h03; end
			default: begin win_len = 3'h2; win_edges = 5'h05; end
		endcase
	end

	// Input transition detection
	always_comb begin
		osc_tog  = osc_s ^ osc_prev_r;
		osc_rise = osc_s & ~osc_prev_r;
	end

	// Supervisor enable and PLL power
	always_comb begin
		sup_on  = (mode != csw_pkg::CSW_MODE_PLL) &&
			!syscfg_r[`CSW_SYSCFG_DIS_BIT];
		pll_run = (mode == csw_pkg::CSW_MODE_PLL) || sup_on ||
			(src_r == csw_pkg::CSW_SRC_FAIL);
		pll_nxt = pll_run;
	end

	// Free-running PLL tick divider, cleared while PLL is off
	always_comb begin
		free_tick    = pll_run && (free_cnt_r == 8'(`CSW_PLL_FREE_CYC - 1));
		free_cnt_nxt = free_cnt_r;
		if (!pll_run || free_tick) begin
			free_cnt_nxt = 8'h00;
		end else begin
			free_cnt_nxt = free_cnt_r + 8'h01;
		end
	end

	// Supervisor counter and switchover
	always_comb begin
		wd_cnt_nxt = wd_cnt_r;
		wd_ovf     = 1'b0;
		src_nxt    = src_r;
		unique case (src_r)
			csw_pkg::CSW_SRC_RUN: begin
				if (!sup_on || osc_tog) begin
					wd_cnt_nxt = 4'h0;
				end else if (free_tick) begin
					if (wd_cnt_r == 4'(`CSW_OVF_TICKS - 5'h01)) begin
						wd_ovf  = 1'b1;
						src_nxt = csw_pkg::CSW_SRC_FAIL;
					end else begin
						wd_cnt_nxt = wd_cnt_r + 4'h1;
					end
				end
			end
			csw_pkg::CSW_SRC_FAIL: src_nxt = csw_pkg::CSW_SRC_FAIL;
			default: src_nxt = csw_pkg::CSW_SRC_RUN;
		endcase
	end

	// PLL model: measure F-transition window, spread edges evenly over it
	always_comb begin
		trans_cnt_nxt = trans_cnt_r;
		ref_cnt_nxt   = (ref_cnt_r == 16'hffff) ? ref_cnt_r : ref_cnt_r + 16'h0001;
		period_nxt    = period_r;
		acc_nxt       = acc_r;
		edge_cnt_nxt  = edge_cnt_r;
		nco_edge      = 1'b0;
		// Spread step runs on the window end too, so its last edge lands there
		if (edge_cnt_r < win_edges) begin
			acc_nxt = acc_r + 16'(win_edges);
			if (acc_nxt >= period_r) begin
				acc_nxt      = acc_nxt - period_r;
				nco_edge     = 1'b1;
				edge_cnt_nxt = edge_cnt_r + 5'h01;
			end
		end
		if (osc_tog) begin
			trans_cnt_nxt = trans_cnt_r + 3'h1;
		end
		if (osc_tog && trans_cnt_r == win_len - 3'h1) begin
			trans_cnt_nxt = 3'h0;
			period_nxt    = ref_cnt_nxt;
			ref_cnt_nxt   = 16'h0000;
			acc_nxt       = 16'h0000;
			edge_cnt_nxt  = 5'h00;
		end
	end

	// CPU clock source selection
	always_comb begin
		cpu_nxt = cpu_clk;
		if (src_r == csw_pkg::CSW_SRC_FAIL) begin
			cpu_nxt = free_tick ? ~cpu_clk : cpu_clk;
		end else begin
			unique case (mode)
				csw_pkg::CSW_MODE_DIRECT:   cpu_nxt = osc_s;
				csw_pkg::CSW_MODE_PRESCALE: cpu_nxt = osc_rise ? ~cpu_clk : cpu_clk;
				csw_pkg::CSW_MODE_PLL:      cpu_nxt = nco_edge ? ~cpu_clk : cpu_clk;
			endcase
		end
		edge_nxt = cpu_nxt ^ cpu_clk;
	end

	// APB slave decode, answer one cycle after setup
	always_comb begin
		acc_wr = psel && penable && pready && pwrite;
		acc_rd = psel && penable && pready && !pwrite;
		hit    = 1'b1;
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			`CSW_OFF_SYSCFG:   rd_nxt = syscfg_r;
			`CSW_OFF_BUSCFG:   rd_nxt = buscfg_r;
			`CSW_OFF_IRQ_STAT: rd_nxt = {31'h0, flag_r};
			`CSW_OFF_IRQ_MASK: rd_nxt = {31'h0, mask_r};
			`CSW_OFF_STATE:    rd_nxt = {25'h0, src_r, mode, strap_r};
			`CSW_OFF_TIMING:   rd_nxt = {23'h0, tristate_hp, wait_hp, 1'b0, ale_ext_hp};
			default:           hit    = 1'b0;
		endcase
		rdy_nxt = psel && !penable;
		err_nxt = psel && !penable && !hit;
		if (!(psel && !penable)) begin
			rd_nxt = prdata;
		end
	end

	// Register writes, flag set beats read clear
	always_comb begin
		syscfg_nxt = syscfg_r;
		buscfg_nxt = buscfg_r;
		mask_nxt   = mask_r;
		if (acc_wr && paddr == `CSW_OFF_SYSCFG) begin
			syscfg_nxt = pwdata;
		end
		if (acc_wr && paddr == `CSW_OFF_BUSCFG) begin
			buscfg_nxt = pwdata;
		end
		if (acc_wr && paddr == `CSW_OFF_IRQ_MASK) begin
			mask_nxt = pwdata[0];
		end
		flag_nxt = flag_r;
		// Clear only a flag that this read returned, so no event is lost
		if (acc_rd && paddr == `CSW_OFF_IRQ_STAT && prdata[0]) begin
			flag_nxt = 1'b0;
		end
		if (wd_ovf) begin
			flag_nxt = 1'b1;
		end
		irq_nxt = flag_nxt & mask_nxt;
	end

	// Bus cycle extensions in CPU half-periods
	always_comb begin
		ale_nxt  = buscfg_r[`CSW_BUS_ALE_BIT];
		wait_nxt = 5'((`CSW_WAIT_BASE - {1'b0, buscfg_r[`CSW_BUS_MCTC_LSB +: 4]}) << 1);
		tri_nxt  = 2'((`CSW_TRI_BASE - {1'b0, buscfg_r[`CSW_BUS_MTTC_BIT]}) << 1);
	end

	// State registers
	always_ff @(posedge ref_clk) begin
		strap_r <= strap_nxt;
		if (reset) begin
			src_r       <= csw_pkg::CSW_SRC_RUN;
			osc_prev_r  <= 1'b0;
			syscfg_r    <= `CSW_SYSCFG_RST;
			buscfg_r    <= `CSW_BUSCFG_RST;
			mask_r      <= `CSW_MASK_RST;
			flag_r      <= 1'b0;
			free_cnt_r  <= 8'h00;
			wd_cnt_r    <= 4'h0;
			trans_cnt_r <= 3'h0;
			ref_cnt_r   <= 16'h0000;
			period_r    <= `CSW_PERIOD_RST;
			acc_r       <= 16'h0000;
			edge_cnt_r  <= 5'h00;
		end else begin
			src_r       <= src_nxt;
			osc_prev_r  <= osc_s;
			syscfg_r    <= syscfg_nxt;
			buscfg_r    <= buscfg_nxt;
			mask_r      <= mask_nxt;
			flag_r      <= flag_nxt;
			free_cnt_r  <= free_cnt_nxt;
			wd_cnt_r    <= wd_cnt_nxt;
			trans_cnt_r <= trans_cnt_nxt;
			ref_cnt_r   <= ref_cnt_nxt;
			period_r    <= period_nxt;
			acc_r       <= acc_nxt;
			edge_cnt_r  <= edge_cnt_nxt;
		end
	end

	// Output registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			cpu_clk      <= 1'b0;
			cpu_edge     <= 1'b0;
			pll_power_on <= 1'b1;
			irq          <= 1'b0;
			ale_ext_hp   <= 1'b0;
			wait_hp      <= 5'h1e;
			tristate_hp  <= 2'h2;
		end else begin
			prdata       <= rd_nxt;
			pready       <= rdy_nxt;
			pslverr      <= err_nxt;
			cpu_clk      <= cpu_nxt;
			cpu_edge     <= edge_nxt;
			pll_power_on <= pll_nxt;
			irq          <= irq_nxt;
			ale_ext_hp   <= ale_nxt;
			wait_hp      <= wait_nxt;
			tristate_hp  <= tri_nxt;
		end
	end
endmodule // csw_clock_ctrl

/* File: test/csw_osc_model.sv */
/*
 * Oscillator source on the far side of the clock select block.
 * Assumes run is driven by the bench; a stopped source holds its level.
 */
`timescale 1ns/1ps
module csw_osc_model #(
	parameter int HALF_NS = 100
) (
	input  wire logic run,
	output logic      osc
);
	// Toggle every half period while running
	initial begin
		osc = 1'b0;
		forever begin
			#(HALF_NS);
			if (run) begin
				osc = ~osc;
			end
		end
	end
endmodule // csw_osc_model

/* File: test/csw_clock_ctrl_sva.sv */
/*
 * Checker of bus answers, clock edge marks, failure and bus timing outputs.
 * Assumes it is bound into csw_clock_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module csw_clock_ctrl_sva (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        cpu_clk,
	input wire logic        cpu_edge,
	input wire logic        pll_power_on,
	input wire logic        irq,
	input wire logic [4:0]  wait_hp,
	input wire logic [1:0]  tristate_hp
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// Bus answer timing
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_no_idle_ready: assert property (!psel |=> !pready)
		else $error("answer without request");
	a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error outside answer or with data");
	// Clock edge marks, failure and bus timing fields
	a_edge_marks_toggle: assert property (cpu_edge == $changed(cpu_clk))
		else $error("edge mark does not match clock toggle");
	a_irq_needs_pll: assert property (irq |-> pll_power_on)
		else $error("failure flag with PLL off");
	a_pll_held_on: assert property (pll_power_on && irq |=> pll_power_on)
		else $error("PLL dropped after switchover");
	a_bus_fields_even: assert property (!wait_hp[0] && !tristate_hp[0])
		else $error("bus extension not whole periods");

	cover property ($rose(irq));
	cover property (pslverr);
	cover property (cpu_edge && pll_power_on);
endmodule // csw_clock_ctrl_sva

bind csw_clock_ctrl csw_clock_ctrl_sva csw_clock_ctrl_sva_i (
	.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .prdata(prdata), .cpu_clk(cpu_clk),
	.cpu_edge(cpu_edge), .pll_power_on(pll_power_on), .irq(irq),
	.wait_hp(wait_hp), .tristate_hp(tristate_hp)
);

/* File: test/csw_clock_ctrl_tb_top.sv */
/*
 * Testbench of the clock select block: bus timing rows, strap codes, failure.
 * Assumes the oscillator model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_clock_ctrl_tb_top;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        osc_run = 1'b1;
	logic        osc;
	logic [2:0]  straps = 3'h3;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, cpu_clk, cpu_edge, pll_on, irq, ale, err;
	logic [4:0]  wait_hp;
	logic [1:0]  tri_hp;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          edges;
	// Rows: alectl, mttc, mctc, expected wait and tristate half-periods
	logic [12:0] rows [4] = '{13'h007a, 13'h1f80, 13'h170a, 13'h08f0};
	// Edges per oscillator period for each strap code
	int          epp [8] = '{5, 1, 3, 2, 10, 4, 6, 8};

	csw_clock_ctrl csw_clock_ctrl_i (.ref_clk(ref_clk), .reset(reset),
		.osc_input_pin(osc), .port0_high_byte(straps), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_clk(cpu_clk),
		.cpu_edge(cpu_edge), .pll_power_on(pll_on), .irq(irq),
		.ale_ext_hp(ale), .wait_hp(wait_hp), .tristate_hp(tri_hp));
	csw_osc_model csw_osc_model_i (.run(osc_run), .osc(osc));

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Edge counts may slip by a resync window boundary
	task automatic chk_near(input string nm, input int exp, input int got);
		samples_checked++;
		if (got < exp - 2 || got > exp + 2) begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// One APB transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic count_edges(input int cyc);
		edges = 0;
		repeat (cyc) begin
			@(posedge ref_clk);
			if (cpu_edge === 1'b1) edges++;
		end
	endtask

	// Reset with straps, check held outputs, then let the clock settle
	task automatic do_reset(input logic [2:0] code);
		straps <= code;
		reset <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("reset outs", {22'h0, 5'h1e, 2'h2, 3'h4}, {22'h0, wait_hp, tri_hp, pll_on, irq, cpu_clk});
		reset <= 1'b0;
		straps <= ~code;
		repeat (240) @(posedge ref_clk);
	endtask

	// Main sequence
	initial begin
		do_reset(3'h3);
		foreach (rows[i]) begin
			apb(1'b1, `CSW_OFF_BUSCFG, {22'h0, rows[i][12], 3'h0, rows[i][11], 1'b0, rows[i][10:7]});
			apb(1'b0, `CSW_OFF_TIMING, 32'h0);
			chk("timing", {23'h0, rows[i][1:0], rows[i][6:2], 1'b0, rows[i][12]}, rd);
			chk("bus ports", {24'h0, rows[i][1:0], rows[i][6:2], rows[i][12]}, {24'h0, tri_hp, wait_hp, ale});
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, `CSW_OFF_STATE, 32'hffffffff);
		apb(1'b0, `CSW_OFF_STATE, 32'h0);
		chk("state ro", 32'h0b, rd);
		for (int c = 0; c < 8; c++) begin
			do_reset(c[2:0]);
			apb(1'b0, `CSW_OFF_STATE, 32'h0);
			chk("state", {25'h0, 2'h0, (c == 1) ? 2'h3 : ((c == 3) ? 2'h1 : 2'h0), c[2:0]}, rd);
			count_edges(320);
			chk_near("edges", 8 * epp[c], edges);
			chk("pll on", 32'h1, {31'h0, pll_on});
		end
		osc_run <= 1'b0;
		repeat (200) @(posedge ref_clk);
		apb(1'b0, `CSW_OFF_STATE, 32'h0);
		chk("pll no watch", 32'h07, rd);
		osc_run <= 1'b1;
		do_reset(3'h3);
		osc_run <= 1'b0;
		repeat (200) @(posedge ref_clk);
		chk("masked irq", 32'h0, {31'h0, irq});
		apb(1'b1, `CSW_OFF_IRQ_MASK, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		osc_run <= 1'b1;
		count_edges(320);
		chk_near("free edges", 80, edges);
		apb(1'b0, `CSW_OFF_STATE, 32'h0);
		chk("fail state", 32'h2b, rd);
		apb(1'b0, `CSW_OFF_IRQ_STAT, 32'h0);
		chk("flag", 32'h1, rd);
		apb(1'b0, `CSW_OFF_IRQ_STAT, 32'h0);
		chk("flag once", 32'h0, rd);
		chk("irq clear", 32'h0, {31'h0, irq});
		do_reset(3'h1);
		apb(1'b1, `CSW_OFF_SYSCFG, 32'h10);
		repeat (4) @(posedge ref_clk);
		chk("pll off", 32'h0, {31'h0, pll_on});
		osc_run <= 1'b0;
		repeat (200) @(posedge ref_clk);
		osc_run <= 1'b1;
		apb(1'b0, `CSW_OFF_STATE, 32'h0);
		chk("no switch", 32'h19, rd);
		count_edges(320);
		chk_near("input edges", 8, edges);
		close_out();
	end

	// Watchdog: tests need about 6600 cycles, allow 100 us
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
endmodule // csw_clock_ctrl_tb_top
